// File: rtl/sdcpi_pkg.sv
// Shared constants and types for the command and power front end
package sdcpi_pkg;

  // Geometry
  localparam int NUM_BANKS   = 8;
  localparam int BANK_W      = 3;
  localparam int ADDR_W      = 14;
  localparam int COL_W       = 10;
  localparam int AP_BIT      = 10;
  localparam int ROW_TOP_BIT = 13;
  localparam int DATA_W      = 8;
  localparam int MEM_COL_W   = 5;
  localparam int MEM_DEPTH   = 256;
  localparam int MEM_IDX_W   = 8;

  // Latency limits, in clock cycles
  localparam logic [2:0] READ_DELAY_MIN   = 3'h3;
  localparam logic [2:0] READ_DELAY_MAX   = 3'h7;
  localparam logic [2:0] POSTED_DELAY_MAX = 3'h6;
  localparam logic [3:0] WRITE_LAT_SUB    = 4'h1;
  localparam int         PIPE_DEPTH       = 16;
  localparam int         PIPE_IDX_W       = 4;
  localparam logic [1:0] PAIRS_BL4        = 2'h1;
  localparam logic [1:0] PAIRS_BL8        = 2'h3;

  // APB map, byte addresses
  localparam int          PADDR_W       = 12;
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_STATUS    = 12'h004;
  localparam logic [11:0] OFS_LATENCY   = 12'h008;

  // Control fields and reset value
  localparam int CTRL_BURST8  = 0;
  localparam int CTRL_ILV     = 1;
  localparam int CTRL_RD_LO   = 2;
  localparam int CTRL_PD_LO   = 5;
  localparam int CTRL_X16     = 8;
  localparam int CTRL_ODT_EN  = 9;
  localparam logic [9:0] CTRL_RESET = 10'h20c;

  // Status and latency fields
  localparam int STAT_PWR_LO  = 0;
  localparam int STAT_OPEN_LO = 8;
  localparam int STAT_ODT     = 16;
  localparam int LAT_WL_LO    = 4;

  // Command code {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_MODE  = 4'h0,
    CMD_REF   = 4'h1,
    CMD_PRE   = 4'h2,
    CMD_ACT   = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_READ  = 4'h5,
    CMD_RSVD  = 4'h6,
    CMD_NOP   = 4'h7
  } sdcpi_cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE   = 2'b00,
    PWR_PRE_PD   = 2'b01,
    PWR_ACT_PD   = 2'b10,
    PWR_SELF_REF = 2'b11
  } sdcpi_pwr_t;

endpackage

// File: rtl/sdcpi_bank_track.sv
// Per-bank open-row tracking
`timescale 1ns/1ns
module sdcpi_bank_track
  import sdcpi_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // Bank events
  input  wire logic                 act,
  input  wire logic                 pre,
  input  wire logic                 pre_all,
  input  wire logic [BANK_W-1:0]    bank,
  input  wire logic [ADDR_W-1:0]    row,
  input  wire logic                 ap_close,
  input  wire logic [BANK_W-1:0]    ap_bank,
  // State
  output logic      [NUM_BANKS-1:0] open_mask
);

  logic [NUM_BANKS-1:0] open_reg;
  logic [NUM_BANKS-1:0] open_next;
  logic [ADDR_W-1:0]    row_reg  [NUM_BANKS];
  logic [ADDR_W-1:0]    row_next [NUM_BANKS];

  // Each bank holds its own row independently
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    always_comb begin
      open_next[b] = open_reg[b];
      row_next[b]  = row_reg[b];
      if (pre_all || (pre && bank == b) || (ap_close && ap_bank == b)) begin
        open_next[b] = 1'b0;
      end
      if (act && bank == b) begin // see RULE9
        open_next[b] = 1'b1;
        row_next[b]  = row;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        open_reg[b] <= 1'b0;
        row_reg[b]  <= '0;
      end else begin
        open_reg[b] <= open_next[b];
        row_reg[b]  <= row_next[b];
      end
    end
  end

  assign open_mask = open_reg;

endmodule // sdcpi_bank_track

// File: rtl/sdcpi_lat_pipe.sv
// Delay line for posted column commands with two latency taps
`timescale 1ns/1ns
module sdcpi_lat_pipe
  import sdcpi_pkg::*;
#(
  parameter int PAY_W = 16
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Column command entry
  input  wire logic                  push,
  input  wire logic                  push_wr,
  input  wire logic [PAY_W-1:0]      push_pay,
  // Taps
  input  wire logic [PIPE_IDX_W-1:0] rd_tap,
  input  wire logic [PIPE_IDX_W-1:0] wr_tap,
  output logic                       rd_hit,
  output logic                       wr_hit,
  output logic      [PAY_W-1:0]      rd_pay,
  output logic      [PAY_W-1:0]      wr_pay
);

  logic             vld_reg  [PIPE_DEPTH];
  logic             vld_next [PIPE_DEPTH];
  logic             wr_reg   [PIPE_DEPTH];
  logic             wr_next  [PIPE_DEPTH];
  logic [PAY_W-1:0] pay_reg  [PIPE_DEPTH];
  logic [PAY_W-1:0] pay_next [PIPE_DEPTH];

  // Stage k holds the command taken k+1 edges ago
  for (genvar k = 0; k < PIPE_DEPTH; k++) begin : g_stage
    if (k == 0) begin : g_head
      always_comb begin
        vld_next[k] = push;
        wr_next[k]  = push_wr;
        pay_next[k] = push_pay;
      end
    end else begin : g_tail
      always_comb begin
        vld_next[k] = vld_reg[k-1];
        wr_next[k]  = wr_reg[k-1];
        pay_next[k] = pay_reg[k-1];
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        vld_reg[k] <= 1'b0;
        wr_reg[k]  <= 1'b0;
        pay_reg[k] <= '0;
      end else begin
        vld_reg[k] <= vld_next[k];
        wr_reg[k]  <= wr_next[k];
        pay_reg[k] <= pay_next[k];
      end
    end
  end

  assign rd_hit = vld_reg[rd_tap] && !wr_reg[rd_tap];
  assign wr_hit = vld_reg[wr_tap] && wr_reg[wr_tap];
  assign rd_pay = pay_reg[rd_tap];
  assign wr_pay = pay_reg[wr_tap];

endmodule // sdcpi_lat_pipe

// File: rtl/sdcpi_core.sv
// Command decode, power states, latency and burst engine with APB settings
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
// Functional notes
// RULE1: Bursts are four or eight beats, wrapping from start column in programmed order.
// RULE2: Controller activates a row before reading or writing that bank.
// RULE3: Activate takes bank from three lines, row from 14 lines or 13 on x16.
// RULE4: Column command takes ten column lines; the autoprecharge bit closes bank afterwards.
// RULE5: Controller finishes initialization before normal traffic.
// RULE6: Read delay setting supports three through seven cycles.
// RULE7: Posted delay of zero through six cycles adds to read latency.
// RULE8: Write latency equals read latency minus one cycle.
// RULE9: Eight independent banks each keep their own open row.
// RULE10: Two words move per cycle from a four-word fetch per column.
// RULE11: Address and control are captured on the rising clock crossing.
// RULE12: Read data gives one beat per half cycle.
// RULE13: Clock gate high enables clocks and buffers; low disables them.
// RULE14: Clock gate low enters precharge power-down or self refresh, else active power-down.
// RULE15: Clock gate sampled synchronously except for self-refresh exit, which is asynchronous.
// RULE16: Controller keeps clock gate high throughout reads and writes.
// RULE17: Power-down keeps only clock, termination and clock-gate buffers on.
// RULE18: Self refresh keeps only the clock-gate buffer on.
// RULE19: Every command is ignored while rank select is registered high.
// RULE20: Rank select is part of the command code.
// RULE21: Command decodes from row strobe, column strobe, write enable and rank select.
// RULE22: Precharge with autoprecharge bit low closes one bank, high closes all.
// RULE23: Write beats with byte mask high are discarded.
// RULE24: Controller honours activate-to-column, precharge and row-active intervals.
// RULE25: Controller refreshes every row within the retention interval.
module sdcpi_core
  import sdcpi_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [PADDR_W-1:0]     paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Command pins
  input  wire logic                   cke,
  input  wire logic                   cs_n,
  input  wire logic                   ras_n,
  input  wire logic                   cas_n,
  input  wire logic                   we_n,
  input  wire logic [BANK_W-1:0]      bank_select_lines,
  input  wire logic [ADDR_W-1:0]      row_col_addr_lines,
  input  wire logic                   termination_enable,
  // Write data, two beats per cycle
  input  wire logic [DATA_W-1:0]      wdata_rise,
  input  wire logic [DATA_W-1:0]      wdata_fall,
  input  wire logic                   write_byte_mask_rise,
  input  wire logic                   write_byte_mask_fall,
  // Read data, two beats per cycle
  output logic      [DATA_W-1:0]      rdata_rise,
  output logic      [DATA_W-1:0]      rdata_fall,
  output logic                        rdata_valid,
  // Power and buffer state
  output logic                        clk_gate_active,
  output logic                        input_buf_en,
  output logic                        odt_buf_en,
  output logic                        odt_applied
);

  localparam int PAY_W = BANK_W + COL_W + 3;

  sdcpi_pwr_t           pwr_reg, pwr_next;
  sdcpi_cmd_t           cmd;
  logic [9:0]           ctrl_reg, ctrl_next;
  logic [31:0]          prdata_reg, prdata_next;
  logic                 err_reg, err_next;
  logic [NUM_BANKS-1:0] open_mask;
  logic                 take, act_ok, pre_ok, col_ok, col_wr;
  logic [ADDR_W-1:0]    act_row;
  logic [3:0]           rl, wl;
  logic [PAY_W-1:0]     push_pay, rd_pay, wr_pay;
  logic                 rd_hit, wr_hit;
  // Burst engines: {ap, bl8, ilv, bank, col}
  logic                 rd_act_reg, rd_act_next, wr_act_reg, wr_act_next;
  logic [1:0]           rd_cnt_reg, rd_cnt_next, wr_cnt_reg, wr_cnt_next;
  logic [PAY_W-1:0]     rd_cmd_reg, rd_cmd_next, wr_cmd_reg, wr_cmd_next;
  logic [DATA_W-1:0]    rdr_reg, rdr_next, rdf_reg, rdf_next;
  logic                 rdv_reg, rdv_next, odt_reg, odt_next;
  logic [DATA_W-1:0]    mem_reg  [MEM_DEPTH];
  logic [DATA_W-1:0]    mem_next [MEM_DEPTH];
  logic [MEM_IDX_W-1:0] rd_idx0, rd_idx1, wr_idx0, wr_idx1;
  logic                 ap_close;
  logic [BANK_W-1:0]    ap_bank;
  logic                 rd_last, wr_last;

  // Column of beat n within the burst block, sequential or interleaved
  function automatic logic [MEM_COL_W-1:0] beat_col(input logic [PAY_W-1:0] c,
                                                    input logic [2:0] n);
    logic [2:0] mask;
    logic [2:0] off;
    mask = c[COL_W+BANK_W+1] ? 3'h7 : 3'h3;
    off  = c[COL_W+BANK_W] ? (c[2:0] ^ n) : (c[2:0] + n);
    return {c[MEM_COL_W-1:3], (c[2:0] & ~mask) | (off & mask)}; // see RULE1
  endfunction

  // Command decode; commands count only while fully awake
  assign cmd  = sdcpi_cmd_t'({cs_n, ras_n, cas_n, we_n}); // see RULE20 see RULE21
  assign take = (pwr_reg == PWR_ACTIVE) && cke && !cs_n; // see RULE19 see RULE11
  assign act_ok = take && cmd == CMD_ACT;
  assign pre_ok = take && cmd == CMD_PRE;
  assign col_wr = cmd == CMD_WRITE;
  assign col_ok = take && (cmd == CMD_READ || col_wr) && open_mask[bank_select_lines];
  // x16 parts drop the top row line
  assign act_row = ctrl_reg[CTRL_X16] ?
                   {1'b0, row_col_addr_lines[ROW_TOP_BIT-1:0]} : row_col_addr_lines; // see RULE3
  assign push_pay = {row_col_addr_lines[AP_BIT], ctrl_reg[CTRL_BURST8], ctrl_reg[CTRL_ILV],
                     bank_select_lines, row_col_addr_lines[COL_W-1:0]}; // see RULE4

  // Total read latency and write latency one less
  assign rl = {1'b0, ctrl_reg[CTRL_RD_LO +: 3]} + {1'b0, ctrl_reg[CTRL_PD_LO +: 3]}; // see RULE7
  assign wl = rl - WRITE_LAT_SUB; // see RULE8

  sdcpi_bank_track u_banks (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .act       (act_ok),
    .pre       (pre_ok),
    .pre_all   (pre_ok && row_col_addr_lines[AP_BIT]), // see RULE22
    .bank      (bank_select_lines),
    .row       (act_row),
    .ap_close  (ap_close),
    .ap_bank   (ap_bank),
    .open_mask (open_mask)
  );

  // Taps lead by the engine flop, reads also by the output flop
  sdcpi_lat_pipe #(.PAY_W(PAY_W)) u_pipe (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .push     (col_ok),
    .push_wr  (col_wr),
    .push_pay (push_pay),
    .rd_tap   (rl - 4'h3),
    .wr_tap   (wl - 4'h2),
    .rd_hit   (rd_hit),
    .wr_hit   (wr_hit),
    .rd_pay   (rd_pay),
    .wr_pay   (wr_pay)
  );

  // Power state machine
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PWR_ACTIVE: begin
        if (!cke) begin // see RULE14
          if (!cs_n && cmd == CMD_REF && open_mask == '0) begin
            pwr_next = PWR_SELF_REF;
          end else if (open_mask != '0) begin
            pwr_next = PWR_ACT_PD;
          end else begin
            pwr_next = PWR_PRE_PD;
          end
        end
      end
      PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF: begin
        if (cke) begin // see RULE15
          pwr_next = PWR_ACTIVE;
        end
      end
      default: pwr_next = PWR_ACTIVE;
    endcase
  end

  // Self-refresh wake does not wait for an edge
  assign clk_gate_active = (pwr_reg == PWR_ACTIVE) ||
                           (pwr_reg == PWR_SELF_REF && cke); // see RULE13 see RULE15
  assign input_buf_en    = pwr_reg == PWR_ACTIVE; // see RULE17
  assign odt_buf_en      = pwr_reg != PWR_SELF_REF; // see RULE18
  assign odt_next        = odt_buf_en && termination_enable && ctrl_reg[CTRL_ODT_EN];

  // Burst engines, one beat pair per cycle
  assign rd_last  = rd_cnt_reg == (rd_cmd_reg[COL_W+BANK_W+1] ? PAIRS_BL8 : PAIRS_BL4);
  assign wr_last  = wr_cnt_reg == (wr_cmd_reg[COL_W+BANK_W+1] ? PAIRS_BL8 : PAIRS_BL4);
  assign rd_idx0  = {rd_cmd_reg[COL_W +: BANK_W], beat_col(rd_cmd_reg, {rd_cnt_reg, 1'b0})};
  assign rd_idx1  = {rd_cmd_reg[COL_W +: BANK_W], beat_col(rd_cmd_reg, {rd_cnt_reg, 1'b1})};
  assign wr_idx0  = {wr_cmd_reg[COL_W +: BANK_W], beat_col(wr_cmd_reg, {wr_cnt_reg, 1'b0})};
  assign wr_idx1  = {wr_cmd_reg[COL_W +: BANK_W], beat_col(wr_cmd_reg, {wr_cnt_reg, 1'b1})};
  assign ap_close = (rd_act_reg && rd_last && rd_cmd_reg[PAY_W-1]) ||
                    (wr_act_reg && wr_last && wr_cmd_reg[PAY_W-1]); // see RULE4
  assign ap_bank  = (wr_act_reg && wr_last && wr_cmd_reg[PAY_W-1]) ?
                    wr_cmd_reg[COL_W +: BANK_W] : rd_cmd_reg[COL_W +: BANK_W];

  always_comb begin
    rd_act_next = rd_act_reg && !rd_last;
    rd_cnt_next = rd_cnt_reg + 2'h1;
    rd_cmd_next = rd_cmd_reg;
    if (rd_hit) begin
      rd_act_next = 1'b1;
      rd_cnt_next = 2'h0;
      rd_cmd_next = rd_pay;
    end
    wr_act_next = wr_act_reg && !wr_last;
    wr_cnt_next = wr_cnt_reg + 2'h1;
    wr_cmd_next = wr_cmd_reg;
    if (wr_hit) begin
      wr_act_next = 1'b1;
      wr_cnt_next = 2'h0;
      wr_cmd_next = wr_pay;
    end
    rdv_next = rd_act_reg;
    rdr_next = rd_act_reg ? mem_reg[rd_idx0] : rdr_reg; // see RULE10 see RULE12
    rdf_next = rd_act_reg ? mem_reg[rd_idx1] : rdf_reg;
  end

  // Storage; masked beats leave the word untouched
  always_comb begin
    for (int i = 0; i < MEM_DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_act_reg && !write_byte_mask_rise) begin // see RULE23
      mem_next[wr_idx0] = wdata_rise;
    end
    if (wr_act_reg && !write_byte_mask_fall) begin // see RULE23
      mem_next[wr_idx1] = wdata_fall;
    end
  end

  // APB: zero wait states, read data loaded in the setup cycle
  always_comb begin
    ctrl_next   = ctrl_reg;
    prdata_next = prdata_reg;
    err_next    = err_reg;
    if (psel && !penable) begin
      err_next    = !(paddr == OFS_CTRL || paddr == OFS_STATUS || paddr == OFS_LATENCY);
      prdata_next = 32'h0000_0000;
      case (paddr)
        OFS_CTRL:    prdata_next[9:0] = ctrl_reg;
        OFS_STATUS:  begin
          prdata_next[STAT_PWR_LO +: 2]          = pwr_reg;
          prdata_next[STAT_OPEN_LO +: NUM_BANKS] = open_mask;
          prdata_next[STAT_ODT]                  = odt_reg;
        end
        OFS_LATENCY: prdata_next[7:0] = {wl, rl};
        default:     prdata_next = 32'h0000_0000;
      endcase
    end
    // Illegal latency codes keep the previous setting
    if (psel && penable && pwrite && paddr == OFS_CTRL &&
        pwdata[CTRL_RD_LO +: 3] >= READ_DELAY_MIN &&
        pwdata[CTRL_PD_LO +: 3] <= POSTED_DELAY_MAX) begin // see RULE6 see RULE7
      ctrl_next = pwdata[9:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwr_reg    <= PWR_ACTIVE;
      ctrl_reg   <= CTRL_RESET;
      prdata_reg <= 32'h0000_0000;
      err_reg    <= 1'b0;
      rd_act_reg <= 1'b0;
      rd_cnt_reg <= 2'h0;
      rd_cmd_reg <= '0;
      wr_act_reg <= 1'b0;
      wr_cnt_reg <= 2'h0;
      wr_cmd_reg <= '0;
      rdr_reg    <= '0;
      rdf_reg    <= '0;
      rdv_reg    <= 1'b0;
      odt_reg    <= 1'b0;
    end else begin
      pwr_reg    <= pwr_next;
      ctrl_reg   <= ctrl_next;
      prdata_reg <= prdata_next;
      err_reg    <= err_next;
      rd_act_reg <= rd_act_next;
      rd_cnt_reg <= rd_cnt_next;
      rd_cmd_reg <= rd_cmd_next;
      wr_act_reg <= wr_act_next;
      wr_cnt_reg <= wr_cnt_next;
      wr_cmd_reg <= wr_cmd_next;
      rdr_reg    <= rdr_next;
      rdf_reg    <= rdf_next;
      rdv_reg    <= rdv_next;
      odt_reg    <= odt_next;
    end
  end

  // Contents are not reset, as in the array itself
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < MEM_DEPTH; i++) begin
      mem_reg[i] <= mem_next[i];
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = 1'b1;
  assign pslverr     = err_reg;
  assign rdata_rise  = rdr_reg;
  assign rdata_fall  = rdf_reg;
  assign rdata_valid = rdv_reg;
  assign odt_applied = odt_reg;

  // Cycles since the last accepted read and since the last accepted write, saturating
  logic [4:0] rd_age_reg, wr_age_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_age_reg <= 5'h1f;
      wr_age_reg <= 5'h1f;
    end else begin
      rd_age_reg <= (col_ok && !col_wr) ? 5'h01 : rd_age_reg + {4'h0, rd_age_reg != 5'h1f};
      wr_age_reg <= (col_ok && col_wr) ? 5'h01 : wr_age_reg + {4'h0, wr_age_reg != 5'h1f};
    end
  end

  sequence s_bl4_data;
    rdata_valid [*2];
  endsequence
  sequence s_bl8_data;
    rdata_valid [*4];
  endsequence

  deselect_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE19
    cs_n && !ap_close |=> $stable(open_mask)) else $error("command taken while deselected");
  activate_open_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE9
    act_ok |=> open_mask[$past(bank_select_lines)]) else $error("activate left bank closed");
  pre_all_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE22
    pre_ok && row_col_addr_lines[AP_BIT] && !act_ok |=> open_mask == '0)
    else $error("precharge all left a bank open");
  burst_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE1
    rd_hit && !rd_pay[COL_W+BANK_W+1] |=> ##1 s_bl4_data)
    else $error("short four-beat read burst");
  burst8_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE10
    rd_hit && rd_pay[COL_W+BANK_W+1] |=> ##1 s_bl8_data)
    else $error("short eight-beat read burst");
  read_latency_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE6
    $rose(rdata_valid) |-> rd_age_reg == {1'b0, rl}) else $error("read latency wrong");
  write_latency_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE8
    $rose(wr_act_reg) |-> wr_age_reg == {1'b0, rl} - 5'h01) else $error("write latency wrong");
  pd_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE14
    pwr_reg == PWR_ACTIVE && !cke && open_mask != '0 |=> pwr_reg == PWR_ACT_PD)
    else $error("active power-down not entered");
  sr_buffers_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE18
    pwr_reg == PWR_SELF_REF && !cke |=> !input_buf_en && !odt_buf_en && !odt_applied)
    else $error("buffers on in self refresh");
  sr_exit_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE15
    pwr_reg == PWR_SELF_REF && cke |-> clk_gate_active ##1 pwr_reg == PWR_ACTIVE)
    else $error("self refresh exit not immediate");
  mask_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE23
    wr_act_reg && write_byte_mask_rise && !(!write_byte_mask_fall && wr_idx1 == wr_idx0)
    |=> mem_reg[$past(wr_idx0)] == $past(mem_reg[wr_idx0])) else $error("masked beat written");

endmodule // sdcpi_core

// File: bench/sdcpi_host_model.sv
// Memory controller model driving command, address and write data
`timescale 1ns/1ns
module sdcpi_host_model
  import sdcpi_pkg::*;
(
  // Clock
  input  wire logic              clk_sys,
  // Pins toward the device
  output logic                   cke = 1'b1,
  output logic [3:0]             cmd_code = 4'h7,
  output logic [BANK_W-1:0]      bank = '0,
  output logic [ADDR_W-1:0]      addr = '0,
  output logic [DATA_W-1:0]      wd_rise = '0,
  output logic [DATA_W-1:0]      wd_fall = '0,
  output logic                   wm_rise = 1'b1,
  output logic                   wm_fall = 1'b1
);
  // One command cycle, then NOP; released lines show the inverse
  task automatic cmd(input logic [3:0] c, input logic [BANK_W-1:0] b,
                     input logic [ADDR_W-1:0] a, input logic k);
    @(posedge clk_sys);
    cmd_code <= c;
    bank <= b;
    addr <= a;
    cke <= k;
    @(posedge clk_sys);
    cmd_code <= 4'h7;
    bank <= ~b;
    addr <= ~a;
  endtask

  // Write burst of four beats, data from write latency on
  task automatic wburst(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] base, input int mb, input int wl);
    cmd(4'h4, b, a, 1'b1);
    repeat (wl - 1) @(posedge clk_sys);
    for (int p = 0; p < 2; p++) begin
      wd_rise <= base + DATA_W'(2 * p);
      wd_fall <= base + DATA_W'(2 * p + 1);
      wm_rise <= (mb == 2 * p);
      wm_fall <= (mb == 2 * p + 1);
      @(posedge clk_sys);
    end
    wd_rise <= ~wd_rise;
    wd_fall <= ~wd_fall;
  endtask
endmodule // sdcpi_host_model

// File: bench/sdcpi_core_tb.sv
// Self-checking bench for the command and power front end
`timescale 1ns/1ns
module sdcpi_core_tb
  import sdcpi_pkg::*;
;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0]        pwdata = '0;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, err, rv, cga, ibe, obe, oda, cke, wmr, wmf;
  logic [DATA_W-1:0]  rdr, rdf, wdr, wdf;
  logic [3:0]         cc;
  logic [BANK_W-1:0]  ba;
  logic [ADDR_W-1:0]  ad;
  int                 errors = 0;
  int                 check_count = 0;

  sdcpi_host_model i_host (.clk_sys(clk_sys), .cke(cke), .cmd_code(cc), .bank(ba),
    .addr(ad), .wd_rise(wdr), .wd_fall(wdf), .wm_rise(wmr), .wm_fall(wmf));
  sdcpi_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cke(cke), .cs_n(cc[3]), .ras_n(cc[2]), .cas_n(cc[1]),
    .we_n(cc[0]), .bank_select_lines(ba), .row_col_addr_lines(ad),
    .termination_enable(1'b1), .wdata_rise(wdr), .wdata_fall(wdf),
    .write_byte_mask_rise(wmr), .write_byte_mask_fall(wmf), .rdata_rise(rdr),
    .rdata_fall(rdf), .rdata_valid(rv), .clk_gate_active(cga), .input_buf_en(ibe),
    .odt_buf_en(obe), .odt_applied(oda));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read burst; rl of 20 means no data may appear
  task automatic rburst(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
                        input logic [31:0] e, input int rl);
    int n;
    i_host.cmd(4'h5, b, a, 1'b1);
    n = 1;
    #1;
    while (rv !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n, rl);
    for (int p = 0; p < 2 && rl < 20; p++) begin
      chk({rdr, rdf}, {e[16*p+:8], e[16*p+8+:8]});
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CTRL, 0); chk(rd, 32'h20c);
    apb(1'b0, OFS_LATENCY, 0); chk(rd, 32'h23);
    apb(1'b0, 12'h00c, 0); chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h208);
    apb(1'b0, OFS_CTRL, 0); chk(rd, 32'h20c);
    apb(1'b1, OFS_CTRL, 32'h2dc);
    apb(1'b0, OFS_LATENCY, 0); chk(rd, 32'hcd);
    apb(1'b1, OFS_CTRL, 32'h254);
    apb(1'b0, OFS_LATENCY, 0); chk(rd, 32'h67);
    i_host.cmd(4'h3, 3'h2, 14'h1abc, 1'b1);
    i_host.cmd(4'h3, 3'h1, 14'h0001, 1'b1);
    i_host.cmd(4'h3, 3'h6, 14'h3fff, 1'b1);
    apb(1'b0, OFS_STATUS, 0); chk(rd, 32'h14600);
    i_host.wburst(3'h2, 14'h0001, 8'h10, 9, 6);
    i_host.wburst(3'h2, 14'h0001, 8'h20, 2, 6);
    apb(1'b1, OFS_CTRL, 32'h257);
    rburst(3'h2, 14'h0001, 32'h21122320, 7);
    apb(1'b1, OFS_CTRL, 32'h254);
    rburst(3'h2, 14'h0400, 32'h12212023, 7);
    apb(1'b0, OFS_STATUS, 0); chk(rd, 32'h14200);
    rburst(3'h2, 14'h0000, 0, 20);
    i_host.cmd(4'h2, 3'h1, 14'h0000, 1'b1);
    i_host.cmd(4'ha, 3'h0, 14'h0400, 1'b1);
    apb(1'b0, OFS_STATUS, 0); chk(rd, 32'h14000);
    i_host.cmd(4'h7, 3'h0, 14'h0000, 1'b0);
    apb(1'b0, OFS_STATUS, 0); chk(rd, 32'h14002);
    chk({cga, ibe, obe}, 3'b001);
    i_host.cmd(4'h7, 3'h0, 14'h0000, 1'b1);
    i_host.cmd(4'h2, 3'h0, 14'h0400, 1'b1);
    i_host.cmd(4'h7, 3'h0, 14'h0000, 1'b0);
    apb(1'b0, OFS_STATUS, 0); chk(rd, 32'h10001);
    i_host.cmd(4'h7, 3'h0, 14'h0000, 1'b1);
    i_host.cmd(4'h1, 3'h0, 14'h0000, 1'b0);
    apb(1'b0, OFS_STATUS, 0); chk(rd, 32'h3);
    chk({cga, ibe, obe, oda}, 4'h0);
    fork
      i_host.cmd(4'h7, 3'h0, 14'h0000, 1'b1);
    join_none
    @(posedge clk_sys);
    #1;
    chk({cga, ibe}, 2'b10);
    apb(1'b0, OFS_STATUS, 0); chk(rd, 32'h0);
    apb(1'b0, OFS_STATUS, 0); chk(rd, 32'h10000);
    end_sim();
  end

  // Hang guard, far beyond the roughly 140 cycles of the sequence
  initial begin
    #50000;
    errors++;
    end_sim();
  end
endmodule // sdcpi_core_tb
